//--- rtl/dio_consts.svh
/*
  Named offsets, field positions, reset values and timing counts for the six-line digital I/O block.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

// Line count and clock rate
`define DIO_NUM_LINES 6
`define DIO_CLK_MHZ 100

// Line indices with a fixed role; line 1 is index 0
`define DIO_IDX_TRIG 3'h0
`define DIO_IDX_MEAS 3'h1
`define DIO_IDX_FAULT 3'h2
`define DIO_IDX_USER 3'h3

// Register byte offsets
`define DIO_OFS_CTRL 8'h00
`define DIO_OFS_CFG_BASE 8'h04
`define DIO_OFS_MANIN_BASE 8'h20
`define DIO_OFS_STATUS 8'h40
`define DIO_OFS_LAST_LINE 8'h14

// Control register fields
`define DIO_CTRL_WORK_LSB 0
`define DIO_CTRL_WORK_MSB 1
`define DIO_CTRL_EXT_TRIG 4

// Line config fields
`define DIO_CFG_MODE_LSB 0
`define DIO_CFG_MODE_MSB 2
`define DIO_CFG_ACT_LSB 4
`define DIO_CFG_ACT_MSB 6
`define DIO_CFG_VAR_LSB 8
`define DIO_CFG_VAR_MSB 9

// Status register fields and write-one commands
`define DIO_ST_PIN_LSB 0
`define DIO_ST_PIN_MSB 5
`define DIO_ST_FAULT 8
`define DIO_ST_ERR_LSB 16
`define DIO_ST_ERR_MSB 25
`define DIO_ST_CLR_FAULT 0
`define DIO_ST_CLR_ERR 1

// Error code for reading a line that is not a manual input
`define DIO_ERR_NOT_MANIN 10'h1FC
`define DIO_ERR_NONE 10'h000

// Measurement-complete low pulse, inside the 10 to 30 us window
`define DIO_MEAS_PULSE_US 20
`define DIO_MEAS_PULSE_CYC (`DIO_MEAS_PULSE_US * `DIO_CLK_MHZ)
`define DIO_MEAS_CNT_W 12

`endif

//--- rtl/dio_pkg.sv
/*
  Types shared by the digital I/O block: work modes, line modes, actions and variations.
  Assumes nothing of its surroundings.
*/
package dio_pkg;
  // Instrument work mode
  typedef enum logic [1:0] {WORK_SUPPLY = 2'h0, WORK_BATT_TEST = 2'h1, WORK_BATT_SIM = 2'h2} work_mode_t;
  // Line mode; manual input is the reset value
  typedef enum logic [2:0] {
    LM_MAN_IN = 3'h0, manual_drive_high = 3'h1, manual_drive_low = 3'h2, LM_TRIG_IN = 3'h3,
    LM_MEAS_DONE = 3'h4, LM_FAULT = 3'h5, LM_COND_OUT = 3'h6, LM_CMD_IN = 3'h7
  } line_mode_t;
  // Condition output actions
  typedef enum logic [2:0] {
    ACT_SINK_SOURCE = 3'h0, over_voltage_action = 3'h1, ACT_UNDER_VOLT = 3'h2, regulation_change_action = 3'h3,
    ACT_END = 3'h4, ACT_FULL = 3'h5, ACT_EMPTY = 3'h6
  } cond_act_t;
  // Command input actions
  typedef enum logic [2:0] {CMD_OUT_ON = 3'h0, CMD_OUT_OFF = 3'h1, CMD_SCRIPT_START = 3'h2, CMD_SCRIPT_STOP = 3'h3} cmd_act_t;
  // Signal variation
  typedef enum logic [1:0] {VAR_RISE = 2'h0, VAR_FALL = 2'h1, VAR_HIGH = 2'h2, VAR_LOW = 2'h3} variation_t;
endpackage

//--- rtl/dio_lines.sv
/*
  Six-line multipurpose digital I/O controller with an APB register slave.
  Assumes pins reach line_in asynchronously, an external open-collector stage driven by line_oe,
  and instrument status/event signals on the pclk domain.
*/
`timescale 1ns/1ps
`include "dio_consts.svh"

module dio_lines
  import dio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] line_in,
  output logic [5:0] line_out,
  output logic [5:0] line_oe,
  input wire logic meas_done,
  input wire logic fault_event,
  input wire logic sink_mode,
  input wire logic cv_mode,
  input wire logic volt_above_limit,
  input wire logic volt_below_limit,
  input wire logic end_reached,
  input wire logic full_reached,
  input wire logic empty_reached,
  output logic trigger_event,
  output logic output_on_cmd,
  output logic output_off_cmd,
  output logic script_start_cmd,
  output logic script_stop_cmd
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////
  work_mode_t work; // Instrument work mode
  line_mode_t mode [`DIO_NUM_LINES]; // Per-line mode
  logic [2:0] act [`DIO_NUM_LINES]; // Per-line action
  variation_t vari [`DIO_NUM_LINES]; // Per-line variation
  logic [5:0] sync1; // First synchroniser stage
  logic [5:0] sync2; // Second synchroniser stage
  logic [5:0] sync3; // Edge history
  logic [5:0] lvl; // 1 = transistor off, line high
  logic [5:0] shot_done; // One-shot already fired
  logic [5:0] cond_q; // Previous condition per line
  logic sink_q; // Previous sink/source state
  logic cv_q; // Previous regulation state
  logic fault_latched; // Pending fault
  logic [9:0] err_code; // Last error code
  logic [`DIO_MEAS_CNT_W-1:0] meas_cnt; // Meter complete pulse timer
  logic bus_access; // Access phase under way
  logic bus_commit; // Transfer completes at this edge
  logic is_cfg; // Address hits a line config
  logic is_manin; // Address hits a manual input read
  logic [2:0] sel_line; // Line chosen by address
  logic next_err; // Error for the pending transfer
  logic [31:0] next_rdata; // Read data for the pending transfer
  logic [5:0] cfg_wr; // Line config written at the previous edge
  ////////////////////////////////////////////////////////////////////////////
  // Legality of a line setting
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic legal(input logic [2:0] ln, input logic [2:0] m, input logic [2:0] a,
                                 input logic [1:0] v, input work_mode_t w);
    logic cond_line;
    logic lvl_act;
    logic lvl_var;
    cond_line = (ln == `DIO_IDX_MEAS) || (ln >= `DIO_IDX_USER);
    lvl_act = (a != ACT_SINK_SOURCE) && (a != regulation_change_action);
    lvl_var = (v == VAR_HIGH) || (v == VAR_LOW);
    case (m)
      LM_MAN_IN, manual_drive_high, manual_drive_low: legal = 1'b1;
      LM_TRIG_IN: legal = (ln == `DIO_IDX_TRIG);
      LM_MEAS_DONE: legal = (ln == `DIO_IDX_MEAS) && (w == WORK_SUPPLY);
      LM_FAULT: legal = (ln == `DIO_IDX_FAULT);
      LM_COND_OUT: begin
        // Change actions one-shot only, voltage actions level only; end, full and empty take either
        legal = cond_line && (w != WORK_SUPPLY) && (lvl_act || !lvl_var) && (a <= ACT_EMPTY);
        legal = legal && (lvl_var || ((a != over_voltage_action) && (a != ACT_UNDER_VOLT)));
        legal = legal && ((w == WORK_BATT_TEST) || ((a != regulation_change_action) && (a != ACT_END)));
        legal = legal && ((w == WORK_BATT_SIM) || (a < ACT_FULL));
      end
      LM_CMD_IN: begin
        legal = cond_line && (w != WORK_SUPPLY) && (a <= CMD_SCRIPT_STOP);
        legal = legal && ((w == WORK_BATT_TEST) || (a < CMD_SCRIPT_START));
      end
      default: legal = 1'b0;
    endcase
  endfunction
  // Current condition of an action from the status inputs
  function automatic logic cond_of(input logic [2:0] a, input logic ss_chg, input logic rg_chg, input logic ov,
                                   input logic uv, input logic en, input logic fu, input logic em);
    case (a)
      ACT_SINK_SOURCE: cond_of = ss_chg;
      over_voltage_action: cond_of = ov;
      ACT_UNDER_VOLT: cond_of = uv;
      regulation_change_action: cond_of = rg_chg;
      ACT_END: cond_of = en;
      ACT_FULL: cond_of = fu;
      ACT_EMPTY: cond_of = em;
      default: cond_of = 1'b0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // APB decode and response preparation
  ////////////////////////////////////////////////////////////////////////////
  assign bus_access = psel && penable;
  assign bus_commit = bus_access && pready;
  assign is_cfg = (paddr >= `DIO_OFS_CFG_BASE) && (paddr <= (`DIO_OFS_CFG_BASE + `DIO_OFS_LAST_LINE))
                  && (paddr[1:0] == 2'b00);
  assign is_manin = (paddr >= `DIO_OFS_MANIN_BASE) && (paddr <= (`DIO_OFS_MANIN_BASE + `DIO_OFS_LAST_LINE))
                    && (paddr[1:0] == 2'b00);
  // Line index and response for the current address
  always_comb begin
    sel_line = 3'((paddr - (is_cfg ? `DIO_OFS_CFG_BASE : `DIO_OFS_MANIN_BASE)) >> 2);
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (paddr == `DIO_OFS_CTRL) begin
      next_rdata[`DIO_CTRL_WORK_MSB:`DIO_CTRL_WORK_LSB] = work;
      next_err = pwrite && (pwdata[`DIO_CTRL_WORK_MSB:`DIO_CTRL_WORK_LSB] > WORK_BATT_SIM);
    end else if (is_cfg) begin
      next_rdata[`DIO_CFG_MODE_MSB:`DIO_CFG_MODE_LSB] = mode[sel_line];
      next_rdata[`DIO_CFG_ACT_MSB:`DIO_CFG_ACT_LSB] = act[sel_line];
      next_rdata[`DIO_CFG_VAR_MSB:`DIO_CFG_VAR_LSB] = vari[sel_line];
      // Illegal settings are refused
      next_err = pwrite && !legal(sel_line, pwdata[`DIO_CFG_MODE_MSB:`DIO_CFG_MODE_LSB],
                                  pwdata[`DIO_CFG_ACT_MSB:`DIO_CFG_ACT_LSB],
                                  pwdata[`DIO_CFG_VAR_MSB:`DIO_CFG_VAR_LSB], work);
    end else if (is_manin) begin
      // Level only for manual inputs, else no data and an error
      next_err = pwrite || (mode[sel_line] != LM_MAN_IN);
      next_rdata[0] = (mode[sel_line] == LM_MAN_IN) && sync2[sel_line];
    end else if (paddr == `DIO_OFS_STATUS) begin
      next_rdata[`DIO_ST_PIN_MSB:`DIO_ST_PIN_LSB] = sync2;
      next_rdata[`DIO_ST_FAULT] = fault_latched;
      next_rdata[`DIO_ST_ERR_MSB:`DIO_ST_ERR_LSB] = err_code;
    end else begin
      next_err = 1'b1; // Unmapped address
    end
  end
  // One wait state, then a registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (bus_access && !pready) begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= next_err ? 32'h0000_0000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work <= WORK_SUPPLY;
      cfg_wr <= 6'h00;
      for (int i = 0; i < `DIO_NUM_LINES; i++) begin
        mode[i] <= LM_MAN_IN;
        act[i] <= 3'h0;
        vari[i] <= VAR_RISE;
      end
    end else begin
      cfg_wr <= 6'h00;
      if (bus_commit && pwrite && !pslverr && (paddr == `DIO_OFS_CTRL)) begin
        work <= work_mode_t'(pwdata[`DIO_CTRL_WORK_MSB:`DIO_CTRL_WORK_LSB]);
        // External trigger source takes over line 1
        if (pwdata[`DIO_CTRL_EXT_TRIG]) begin
          mode[0] <= LM_TRIG_IN;
          cfg_wr[0] <= 1'b1;
        end
      end
      if (bus_commit && pwrite && !pslverr && is_cfg) begin
        mode[sel_line] <= line_mode_t'(pwdata[`DIO_CFG_MODE_MSB:`DIO_CFG_MODE_LSB]);
        act[sel_line] <= pwdata[`DIO_CFG_ACT_MSB:`DIO_CFG_ACT_LSB];
        vari[sel_line] <= variation_t'(pwdata[`DIO_CFG_VAR_MSB:`DIO_CFG_VAR_LSB]);
        cfg_wr[sel_line] <= 1'b1;
      end
    end
  end
  // Error code and fault latch; a new fault wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code <= `DIO_ERR_NONE;
      fault_latched <= 1'b0;
    end else begin
      if (bus_commit && is_manin && pslverr && !pwrite) begin
        err_code <= `DIO_ERR_NOT_MANIN;
      end else if (bus_commit && pwrite && (paddr == `DIO_OFS_STATUS) && pwdata[`DIO_ST_CLR_ERR]) begin
        err_code <= `DIO_ERR_NONE;
      end
      if (fault_event) begin
        fault_latched <= 1'b1;
      end else if (bus_commit && pwrite && (paddr == `DIO_OFS_STATUS) && pwdata[`DIO_ST_CLR_FAULT]) begin
        fault_latched <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and trigger/command events
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
      sync3 <= 6'h3F;
    end else begin
      sync1 <= line_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // Single-cycle pulses from synchronised edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_event <= 1'b0;
      output_on_cmd <= 1'b0;
      output_off_cmd <= 1'b0;
      script_start_cmd <= 1'b0;
      script_stop_cmd <= 1'b0;
    end else begin
      // Falling edge, three cycles after the pin
      trigger_event <= (mode[0] == LM_TRIG_IN) && sync3[0] && !sync2[0];
      output_on_cmd <= 1'b0;
      output_off_cmd <= 1'b0;
      script_start_cmd <= 1'b0;
      script_stop_cmd <= 1'b0;
      for (int i = 0; i < `DIO_NUM_LINES; i++) begin
        // Rise and high act on a rising edge, fall and low on a falling edge
        if ((mode[i] == LM_CMD_IN) && (sync2[i] != sync3[i])
            && (sync2[i] == ((vari[i] == VAR_RISE) || (vari[i] == VAR_HIGH)))) begin
          case (act[i])
            CMD_OUT_ON: output_on_cmd <= 1'b1;
            CMD_OUT_OFF: output_off_cmd <= 1'b1;
            CMD_SCRIPT_START: script_start_cmd <= 1'b1;
            CMD_SCRIPT_STOP: script_stop_cmd <= 1'b1;
            default: output_on_cmd <= 1'b0;
          endcase
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Measurement-complete pulse timer
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_cnt <= '0;
    end else if (meas_done && (mode[1] == LM_MEAS_DONE)) begin
      meas_cnt <= `DIO_MEAS_CNT_W'(`DIO_MEAS_PULSE_CYC);
    end else if (meas_cnt != '0) begin
      meas_cnt <= meas_cnt - 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output level per line
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= 6'h3F;
      shot_done <= 6'h00;
      cond_q <= 6'h00;
      sink_q <= 1'b0;
      cv_q <= 1'b0;
    end else begin
      sink_q <= sink_mode;
      cv_q <= cv_mode;
      for (int i = 0; i < `DIO_NUM_LINES; i++) begin
        cond_q[i] <= cond_of(act[i], sink_mode ^ sink_q, cv_mode ^ cv_q, volt_above_limit,
                             volt_below_limit, end_reached, full_reached, empty_reached);
        case (mode[i])
          manual_drive_high: lvl[i] <= 1'b1;
          manual_drive_low: lvl[i] <= 1'b0;
          LM_MEAS_DONE: lvl[i] <= (meas_cnt == '0);
          LM_FAULT: lvl[i] <= !fault_latched;
          LM_COND_OUT: begin
            if (cfg_wr[i]) begin
              // Fresh setting re-arms the one-shot at its resting level
              shot_done[i] <= 1'b0;
              lvl[i] <= (vari[i] != VAR_RISE) && (vari[i] != VAR_HIGH);
            end else if ((vari[i] == VAR_HIGH) || (vari[i] == VAR_LOW)) begin
              lvl[i] <= cond_q[i] ^ (vari[i] == VAR_LOW);
            end else if (!shot_done[i] && cond_q[i]) begin
              shot_done[i] <= 1'b1;
              lvl[i] <= (vari[i] == VAR_RISE);
            end
          end
          default: lvl[i] <= 1'b1; // Inputs leave the transistor off
        endcase
      end
    end
  end
  // Open-collector stage: enable sinks, pad level is always low when driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_oe <= 6'h00;
      line_out <= 6'h00;
    end else begin
      line_oe <= ~lvl;
      line_out <= 6'h00;
    end
  end
endmodule // dio_lines

//--- dv/dio_lines_chk.sv
/*
  Port-level checker for the six-line digital I/O block.
  Assumes it is bound to dio_lines and sees only that module's ports.
*/
`timescale 1ns/1ps
module dio_lines_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [5:0] line_in,
  input wire logic [5:0] line_out,
  input wire logic [5:0] line_oe,
  input wire logic trigger_event,
  input wire logic output_on_cmd
);
  // One clock domain, reset disables every check
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed write on the register bus
  wire logic commit = psel && penable && pwrite && pready;
  //////////////////////////////////////////////////////////////////////////////
  a_reset_lines: assert property ($rose(presetn) |-> line_oe == 6'h00)
    else $error("line driven right after reset");
  a_out_sink: assert property (line_out == 6'h00)
    else $error("line output not held at sink level");
  a_trig_edge: assert property (trigger_event |-> !$past(line_in[0], 3))
    else $error("trigger event without low pin");
  a_trig_single: assert property (trigger_event |=> !trigger_event)
    else $error("trigger event longer than one cycle");
  a_cmd_single: assert property (output_on_cmd |=> !output_on_cmd)
    else $error("output on command longer than one cycle");
  a_fault_hold: assert property ($fell(line_oe[2]) |-> $past(commit) || $past(commit, 2)
    || $past(commit, 3) || $past(commit, 4)) else $error("fault line released without a write");
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_pready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("bad answer strobe");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule // dio_lines_chk

bind dio_lines dio_lines_chk dio_lines_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .line_in, .line_out, .line_oe, .trigger_event, .output_on_cmd);

//--- dv/dio_far_end.sv
/*
  Far side of the six lines: pull-ups, an open-collector driver of the bench and relay loads.
  Assumes line_oe high means the block sinks the line.
*/
`timescale 1ns/1ps
module dio_far_end (
  input wire logic [5:0] line_oe,
  input wire logic [5:0] hold_low,
  output logic [5:0] line_in,
  output logic [5:0] relay_on
);
  // Wired-AND: any sinking party pulls low, else the pull-up wins
  assign line_in = ~(line_oe | hold_low);
  // Load energised while the line is low
  assign relay_on = ~line_in;
endmodule // dio_far_end

//--- dv/tb_top.sv
/*
  Self-checking bench for the six-line digital I/O block.
  Assumes dio_pkg, dio_lines, dio_far_end and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb_top;
  import dio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_done, fault_event, err;
  logic [7:0] paddr; // Bus address
  logic [31:0] pwdata, prdata, rd; // Bus data and last read
  logic [5:0] line_in, line_out, line_oe, hold_low, relay_on; // Pins and far-side drive
  logic [6:0] st; // Status inputs in action order
  logic trigger_event, output_on_cmd, output_off_cmd, script_start_cmd, script_stop_cmd;
  logic [3:0] cmds; // Command pulses in action order
  int num_errors = 0;
  int check_count = 0;
  assign cmds = {script_stop_cmd, script_start_cmd, output_off_cmd, output_on_cmd};
  dio_lines dio_lines_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .line_in, .line_out, .line_oe, .meas_done, .fault_event, .sink_mode(st[0]),
    .volt_above_limit(st[1]), .volt_below_limit(st[2]), .cv_mode(st[3]), .end_reached(st[4]),
    .full_reached(st[5]), .empty_reached(st[6]), .trigger_event, .output_on_cmd, .output_off_cmd,
    .script_start_cmd, .script_stop_cmd);
  dio_far_end dio_far_end_inst (.line_oe, .hold_low, .line_in, .relay_on);
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts and verdict
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One bus transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Line setting word
  function automatic logic [31:0] cfgw(line_mode_t m, logic [2:0] a, variation_t v);
    return {22'h0, v, 1'b0, a, 1'b0, m};
  endfunction
  task automatic try_cfg(work_mode_t wm, logic [7:0] a, line_mode_t m, logic [2:0] act, variation_t v, logic e);
    apb(1'b1, 8'h00, {30'h0, wm});
    apb(1'b1, a, cfgw(m, act, v));
    check(32'(err), 32'(e));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Defaults and manual input readback
  task automatic t_reset();
    check(32'(line_oe), 32'h0);
    for (int n = 0; n < 6; n++) begin
      apb(1'b0, 8'h04 + 8'(4 * n), 32'h0);
      check(rd, 32'h0);
    end
    hold_low[3] <= 1'b1;
    step(6);
    apb(1'b0, 8'h2C, 32'h0);
    check(32'({err, rd[0]}), 32'h0);
    hold_low[3] <= 1'b0;
    step(6);
    apb(1'b0, 8'h2C, 32'h0);
    check(32'({err, rd[0]}), 32'h1);
  endtask
  // Manual drive and refused input read
  task automatic t_manual();
    apb(1'b1, 8'h10, cfgw(manual_drive_low, 3'h0, VAR_RISE));
    step(6);
    check(32'({line_oe[3], line_in[3], line_out[3], relay_on[3]}), 32'h9);
    apb(1'b0, 8'h2C, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(rd[25:16]), 32'h0000_01FC);
    apb(1'b1, 8'h40, 32'h2);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(rd[25:16]), 32'h0);
    apb(1'b1, 8'h10, cfgw(manual_drive_high, 3'h0, VAR_RISE));
    step(6);
    check(32'({line_oe[3], line_in[3], relay_on[3]}), 32'h2);
  endtask
  // Line and work mode table
  task automatic t_modes();
    try_cfg(WORK_SUPPLY, 8'h08, LM_MEAS_DONE, 3'h0, VAR_RISE, 1'b0);
    try_cfg(WORK_SUPPLY, 8'h10, LM_MEAS_DONE, 3'h0, VAR_RISE, 1'b1);
    try_cfg(WORK_SUPPLY, 8'h04, LM_FAULT, 3'h0, VAR_RISE, 1'b1);
    try_cfg(WORK_SUPPLY, 8'h08, LM_TRIG_IN, 3'h0, VAR_RISE, 1'b1);
    try_cfg(WORK_SUPPLY, 8'h10, LM_COND_OUT, ACT_SINK_SOURCE, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_TEST, 8'h08, LM_MEAS_DONE, 3'h0, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_TEST, 8'h0C, LM_CMD_IN, CMD_OUT_ON, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_TEST, 8'h14, LM_CMD_IN, CMD_SCRIPT_START, VAR_RISE, 1'b0);
    try_cfg(WORK_BATT_TEST, 8'h14, LM_COND_OUT, ACT_SINK_SOURCE, VAR_HIGH, 1'b1);
    try_cfg(WORK_BATT_TEST, 8'h18, LM_COND_OUT, over_voltage_action, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_SIM, 8'h10, LM_COND_OUT, ACT_END, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_SIM, 8'h10, LM_CMD_IN, CMD_SCRIPT_START, VAR_RISE, 1'b1);
    try_cfg(WORK_BATT_SIM, 8'h10, LM_COND_OUT, ACT_FULL, VAR_RISE, 1'b0);
    try_cfg(WORK_SUPPLY, 8'h04, manual_drive_low, 3'h0, VAR_RISE, 1'b0);
  endtask
  // Forced trigger mode and a 4 us low pulse
  task automatic t_trigger();
    int cnt = 0;
    int at = -1;
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    check(32'(rd[2:0]), 32'(LM_TRIG_IN));
    step(6);
    hold_low[0] <= 1'b1;
    for (int i = 0; i < 450; i++) begin
      @(posedge pclk);
      if (i == 399) hold_low[0] <= 1'b0;
      if (trigger_event === 1'b1) cnt++;
      if (trigger_event === 1'b1 && at < 0) at = i;
    end
    check(32'(cnt), 32'h1);
    check(32'(at >= 0 && at < 500), 32'h1);
  endtask
  // Measurement complete low pulse width
  task automatic t_meas();
    int w = 0;
    int rises = 0;
    logic prev = 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, cfgw(LM_MEAS_DONE, 3'h0, VAR_RISE));
    step(6);
    check(32'(line_oe[1]), 32'h0);
    meas_done <= 1'b1;
    step(1);
    meas_done <= 1'b0;
    repeat (3500) begin
      @(posedge pclk);
      if (line_oe[1] === 1'b1) w++;
      if (line_oe[1] === 1'b1 && !prev) rises++;
      prev = line_oe[1];
    end
    check(32'(rises), 32'h1);
    check(32'(w >= 1000 && w <= 3000), 32'h1);
  endtask
  // Fault line set, held, cleared
  task automatic t_fault();
    apb(1'b1, 8'h0C, cfgw(LM_FAULT, 3'h0, VAR_RISE));
    step(6);
    check(32'(line_oe[2]), 32'h0);
    fault_event <= 1'b1;
    step(1);
    fault_event <= 1'b0;
    step(200);
    apb(1'b0, 8'h40, 32'h0);
    check(32'({rd[8], line_oe[2], line_in[2]}), 32'h6);
    apb(1'b1, 8'h40, 32'h1);
    step(6);
    check(32'(line_oe[2]), 32'h0);
  endtask
  // Every condition action, each with one variation
  task automatic t_cond();
    variation_t vt [7] = '{VAR_RISE, VAR_HIGH, VAR_LOW, VAR_FALL, VAR_FALL, VAR_HIGH, VAR_RISE};
    logic lo;
    logic once;
    for (int a = 0; a < 7; a++) begin
      lo = (vt[a] == VAR_FALL || vt[a] == VAR_LOW);
      once = (vt[a] == VAR_RISE || vt[a] == VAR_FALL);
      st <= 7'h00;
      apb(1'b1, 8'h00, (a >= 5) ? 32'h2 : 32'h1);
      apb(1'b1, 8'h14, cfgw(LM_COND_OUT, 3'(a), vt[a]));
      check(32'(err), 32'h0);
      step(6);
      check(32'(line_oe[4]), 32'(!lo));
      st[a] <= 1'b1;
      step(6);
      check(32'(line_oe[4]), 32'(lo));
      st[a] <= 1'b0;
      step(6);
      check(32'(line_oe[4]), 32'(once ? lo : !lo));
    end
  endtask
  // Every command action on a rising pin
  task automatic t_cmd();
    logic [3:0] got;
    int cnt;
    apb(1'b1, 8'h00, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h10, cfgw(LM_CMD_IN, 3'(c), VAR_RISE));
      step(10);
      got = 4'h0;
      cnt = 0;
      hold_low[3] <= 1'b1;
      for (int i = 0; i < 30; i++) begin
        @(posedge pclk);
        if (i == 9) hold_low[3] <= 1'b0;
        if ((|cmds) === 1'b1) cnt++;
        got = got | cmds;
      end
      check(32'(cnt), 32'h1);
      check(32'(got), 32'(4'h1 << c));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold_low = 6'h00;
    meas_done = 1'b0;
    fault_event = 1'b0;
    st = 7'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_manual();
    t_modes();
    t_trigger();
    t_meas();
    t_fault();
    t_cond();
    t_cmd();
    finish_test();
  end
endmodule // tb_top
